// [hw/plb_pkg.sv]
// Package: register map, field positions, path states and nibble carrier for loopback block
package plb_pkg;
   localparam int unsigned PLB_AW = 8;
   localparam int unsigned PLB_DW = 32;
   // Register byte offsets
   localparam logic [PLB_AW-1:0] PLB_CTRL_OFS = 8'h00;
   localparam logic [PLB_AW-1:0] PLB_STAT_OFS = 8'h04;
   localparam logic [PLB_AW-1:0] PLB_MODE_OFS = 8'h08;
   localparam logic [PLB_AW-1:0] PLB_EVT_OFS  = 8'h0C;
   localparam logic [PLB_AW-1:0] PLB_ERRC_OFS = 8'h10;
   localparam logic [PLB_AW-1:0] PLB_PRE_OFS  = 8'h14;
   // Basic control fields
   localparam int unsigned CTRL_SRST = 15;
   localparam int unsigned CTRL_LOOP = 14;
   localparam int unsigned CTRL_SPD  = 13;
   localparam int unsigned CTRL_ANEN = 12;
   localparam int unsigned CTRL_PDN  = 11;
   localparam int unsigned CTRL_ISO  = 10;
   localparam int unsigned CTRL_ANRS = 9;
   localparam int unsigned CTRL_DUP  = 8;
   localparam int unsigned CTRL_COLT = 7;
   localparam int unsigned CTRL_LO   = 7;
   localparam logic [15:0] PLB_CTRL_RST = 16'h3100;
   // Status fields
   localparam int unsigned STAT_ERR  = 4;
   localparam int unsigned STAT_LINK = 2;
   // Mode control/status fields
   localparam int unsigned MODE_ECHO = 9;
   localparam int unsigned MODE_RMII = 8;
   localparam int unsigned MODE_KHI  = 7;
   localparam int unsigned MODE_KLO  = 4;
   localparam int unsigned MODE_RUN  = 1;
   localparam logic [3:0]  PLB_KEEP_RST = 4'h0;
   // Event fields
   localparam int unsigned EVT_TXS  = 0;
   localparam int unsigned EVT_RXS  = 1;
   localparam int unsigned EVT_ECHO = 8;

   typedef enum logic [2:0] {
      PLB_NORMAL = 3'b001,
      PLB_NEAR   = 3'b010,
      PLB_FAR    = 3'b100
   } plb_path_e;

   typedef struct packed {
      logic       en;
      logic [3:0] d;
   } plb_nib_s;
endpackage

// [hw/plb_sync.sv]
// Two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module plb_sync #(
   parameter int unsigned W = 8
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta;

   // First stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (rst) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// [hw/plb_top.sv]
// Loopback path control with management register file on APB
`timescale 1ns/100ps

module plb_top
   import plb_pkg::*;
#(
   parameter int unsigned LOOP_DEPTH = 3
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst,
   // APB slave
   input  wire logic [PLB_AW-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [PLB_DW-1:0] pwdata,
   output logic      [PLB_DW-1:0] prdata,
   output logic                   pready,
   output logic                   pslverr,
   // MAC side
   input  wire plb_nib_s          mac_tx,
   output plb_nib_s               mac_rx,
   output logic                   mac_col,
   // Line side pins
   input  wire plb_nib_s          line_rx,
   input  wire logic              line_rx_err,
   input  wire logic              line_link_ok,
   input  wire logic              rmii_mode,
   output plb_nib_s               line_tx,
   output logic                   line_tx_pwr_en
);
   localparam int unsigned PD = LOOP_DEPTH + 1;

   function automatic logic hit(input logic [PLB_AW-1:0] a, input logic [PLB_AW-1:0] o);
      return a == o;
   endfunction

   plb_nib_s     s_rx;
   logic         s_err;
   logic         s_link;
   logic         s_rmii;
   logic [15:0]  ctrl;
   logic         mode_echo;
   logic         mode_run;
   logic [3:0]   mode_keep;
   logic         stat_link;
   logic         stat_err;
   logic         evt_tx;
   logic         evt_rx;
   logic         evt_echo;
   logic [15:0]  errcnt;
   logic         err_d;
   logic         tx_en_d;
   logic         rx_en_d;
   plb_path_e    path;
   plb_path_e    next_path;
   plb_nib_s     pipe [LOOP_DEPTH];
   logic [31:0]  next_rdata;
   logic         mapped;
   logic         srst;
   logic         setup;
   logic         wr;
   logic         rd;
   logic         err_rise;
   logic         tx_rise;
   logic         rx_rise;
   logic         echo_set;

   plb_sync #(.W(8)) u_sync (
      .clk (clk),
      .rst (rst),
      .d   ({rmii_mode, line_link_ok, line_rx_err, line_rx}),
      .q   ({s_rmii, s_link, s_err, s_rx})
   );

   // Soft reset lasts one cycle: the bit that starts it is itself cleared by it
   assign srst     = rst | ctrl[CTRL_SRST];
   assign setup    = psel & ~penable;
   assign wr       = psel & penable & pready & pwrite;
   assign rd       = psel & penable & pready & ~pwrite;
   assign err_rise = s_err & ~err_d;
   assign tx_rise  = mac_tx.en & ~tx_en_d;
   assign rx_rise  = s_rx.en & ~rx_en_d;
   assign echo_set = (path == PLB_FAR) & s_rx.en;

   always_ff @(posedge clk) begin
      if (srst) begin
         err_d   <= 1'b0;
         tx_en_d <= 1'b0;
         rx_en_d <= 1'b0;
      end else begin
         err_d   <= s_err;
         tx_en_d <= mac_tx.en;
         rx_en_d <= s_rx.en;
      end
   end

   // Read data mux; reserved bits and the write-only register read as zero
   always_comb begin
      next_rdata = '0;
      mapped     = 1'b1;
      case (paddr)
         PLB_CTRL_OFS: next_rdata[15:0] = ctrl;
         PLB_STAT_OFS: begin
            next_rdata[STAT_ERR]  = stat_err;
            next_rdata[STAT_LINK] = stat_link;
         end
         PLB_MODE_OFS: begin
            next_rdata[MODE_ECHO]          = mode_echo;
            next_rdata[MODE_RMII]          = s_rmii;
            next_rdata[MODE_KHI:MODE_KLO]  = mode_keep;
            next_rdata[MODE_RUN]           = mode_run;
         end
         PLB_EVT_OFS: begin
            next_rdata[EVT_TXS]  = evt_tx;
            next_rdata[EVT_RXS]  = evt_rx;
            next_rdata[EVT_ECHO] = evt_echo;
         end
         PLB_ERRC_OFS: next_rdata[15:0] = errcnt;
         PLB_PRE_OFS:  next_rdata = '0;
         default:      mapped = 1'b0;
      endcase
   end

   // Zero-wait answer: data sampled in setup, presented in the access cycle
   always_ff @(posedge clk) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= setup;
         pslverr <= setup & ~mapped;
         if (setup) begin
            prdata <= next_rdata;
         end
      end
   end

   // Basic control; reserved low bits never take written values
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl <= PLB_CTRL_RST;
      end else begin
         ctrl[CTRL_ANRS] <= 1'b0;
         if (wr && hit(paddr, PLB_CTRL_OFS)) begin
            ctrl[15:CTRL_LO] <= pwdata[15:CTRL_LO];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         mode_echo <= 1'b0;
         mode_run  <= 1'b1;
      end else begin
         mode_run <= 1'b1;
         if (wr && hit(paddr, PLB_MODE_OFS)) begin
            mode_echo <= pwdata[MODE_ECHO];
            if (!pwdata[MODE_RUN]) begin
               mode_run <= 1'b0;
            end
         end
      end
   end

   // Only the hard reset reaches this field
   always_ff @(posedge clk) begin
      if (rst) begin
         mode_keep <= PLB_KEEP_RST;
      end else if (wr && hit(paddr, PLB_MODE_OFS)) begin
         mode_keep <= pwdata[MODE_KHI:MODE_KLO];
      end
   end

   // Clear only what the read reported, so an event during the read survives
   always_ff @(posedge clk) begin
      if (srst) begin
         stat_link <= 1'b0;
         stat_err  <= 1'b0;
      end else if (rd && hit(paddr, PLB_STAT_OFS)) begin
         stat_link <= (stat_link | ~prdata[STAT_LINK]) & s_link;
         stat_err  <= (stat_err & ~prdata[STAT_ERR]) | s_err;
      end else begin
         stat_link <= stat_link & s_link;
         stat_err  <= stat_err | s_err;
      end
   end

   // Writes to the counter offset are ignored; a preset comes only from the write-only word
   always_ff @(posedge clk) begin
      if (srst) begin
         errcnt <= '0;
      end else if (rd && hit(paddr, PLB_ERRC_OFS)) begin
         errcnt <= errcnt - prdata[15:0] + {15'h0000, err_rise};
      end else if (wr && hit(paddr, PLB_PRE_OFS)) begin
         errcnt <= pwdata[15:0];
      end else begin
         errcnt <= errcnt + {15'h0000, err_rise};
      end
   end

   // Set wins over clear on every event flag
   always_ff @(posedge clk) begin
      if (srst) begin
         evt_tx   <= 1'b0;
         evt_rx   <= 1'b0;
         evt_echo <= 1'b0;
      end else begin
         evt_tx   <= (evt_tx & ~(wr && hit(paddr, PLB_EVT_OFS) && pwdata[EVT_TXS]))
                     | tx_rise;
         evt_rx   <= (evt_rx & ~(wr && hit(paddr, PLB_EVT_OFS) && pwdata[EVT_RXS]))
                     | rx_rise;
         evt_echo <= (evt_echo & ~(wr && hit(paddr, PLB_EVT_OFS))) | echo_set;
      end
   end

   // Near loopback outranks far loopback
   always_comb begin
      if (ctrl[CTRL_LOOP]) begin
         next_path = PLB_NEAR;
      end else if (mode_echo && s_rmii) begin
         next_path = PLB_FAR;
      end else begin
         next_path = PLB_NORMAL;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         path <= PLB_NORMAL;
      end else begin
         path <= next_path;
      end
   end

   // Coding, attachment and medium stages of the internal loop
   always_ff @(posedge clk) begin
      if (srst || !mode_run) begin
         for (int i = 0; i < LOOP_DEPTH; i++) begin
            pipe[i] <= '0;
         end
      end else begin
         pipe[0] <= mac_tx;
         for (int i = 1; i < LOOP_DEPTH; i++) begin
            pipe[i] <= pipe[i-1];
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         line_tx        <= '0;
         line_tx_pwr_en <= 1'b0;
         mac_rx         <= '0;
         mac_col        <= 1'b0;
      end else begin
         line_tx_pwr_en <= (path != PLB_NEAR) & ~ctrl[CTRL_PDN];
         unique case (path)
            PLB_NEAR: begin
               line_tx <= '0;
               mac_rx  <= ctrl[CTRL_ISO] ? '0 : pipe[LOOP_DEPTH-1];
               mac_col <= ctrl[CTRL_COLT] & mac_tx.en & ~ctrl[CTRL_ISO];
            end
            PLB_FAR: begin
               line_tx <= s_rx;
               mac_rx  <= '0;
               mac_col <= 1'b0;
            end
            PLB_NORMAL: begin
               // Receive is not gated by transmit, so a looped cable still links
               line_tx <= mac_tx;
               mac_rx  <= ctrl[CTRL_ISO] ? '0 : s_rx;
               mac_col <= ~ctrl[CTRL_ISO] & mac_tx.en
                          & (ctrl[CTRL_COLT] | (~ctrl[CTRL_DUP] & s_rx.en));
            end
         endcase
      end
   end

   // Cycles spent steadily in the internal loop, for checking its latency
   logic [3:0] near_cnt;
   always_ff @(posedge clk) begin
      if (srst || path != PLB_NEAR || !mode_run || ctrl[CTRL_ISO]) begin
         near_cnt <= '0;
      end else if (near_cnt != 4'hF) begin
         near_cnt <= near_cnt + 4'h1;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_near_entry: assert property ($rose(ctrl[CTRL_LOOP]) |=> path == PLB_NEAR)
      else $error("near loopback not entered");
   a_near_data: assert property (near_cnt > 4'(PD) |-> mac_rx == $past(mac_tx, PD))
      else $error("near loop data mismatch");
   a_col_quiet: assert property (path == PLB_NEAR && !ctrl[CTRL_COLT] |=> !mac_col)
      else $error("collision active in near loop");
   a_tx_off: assert property (path == PLB_NEAR |=> !line_tx_pwr_en && line_tx == '0)
      else $error("transmitter on in near loop");
   a_far_echo: assert property (path == PLB_FAR |=> line_tx == $past(s_rx))
      else $error("far echo mismatch");
   a_far_iso: assert property (path == PLB_FAR |=> mac_rx == '0 && !mac_col)
      else $error("mac side not isolated");
   a_far_rmii: assert property (path == PLB_FAR |-> $past(s_rmii) && $past(mode_echo))
      else $error("far loop outside reduced mode");
   a_wc_clear: assert property (wr && hit(paddr, PLB_EVT_OFS) && pwdata[EVT_TXS]
      && !tx_rise && !ctrl[CTRL_SRST] |=> !evt_tx)
      else $error("write one did not clear");
   a_wac_clear: assert property (wr && hit(paddr, PLB_EVT_OFS) && !echo_set |=> !evt_echo)
      else $error("write any did not clear");
   a_sticky_err: assert property (stat_err && !(rd && hit(paddr, PLB_STAT_OFS))
      && !ctrl[CTRL_SRST] |=> stat_err)
      else $error("sticky status dropped");
   a_run_self: assert property (!mode_run |=> mode_run)
      else $error("self-set bit stuck low");
   a_keep_cfg: assert property (ctrl[CTRL_SRST] |=> $stable(mode_keep))
      else $error("immune field lost on soft reset");
   a_srst_sc: assert property (ctrl[CTRL_SRST] |=> !ctrl[CTRL_SRST] ##0 ctrl == PLB_CTRL_RST)
      else $error("soft reset not self-cleared");

   c_near_run: cover property (near_cnt > 4'(PD) && mac_rx.en);
   c_far_echo: cover property (path == PLB_FAR && s_rx.en);
   c_stat_read: cover property (rd && hit(paddr, PLB_STAT_OFS) && stat_err);
endmodule

// [verification/plb_line_model.sv]
// Line partner model: remote station pattern source or short loopback cable
`timescale 1ns/100ps
module plb_line_model
   import plb_pkg::*;
(
   // Clock
   input  wire logic     clk,
   // Control from bench
   input  wire logic     cable,
   input  wire plb_nib_s pat,
   // Line pins
   input  wire plb_nib_s line_tx,
   output plb_nib_s      line_rx
);
   logic [3:0] idle_d = 4'h0;
   plb_nib_s   src;

   // Idle data lines wander so a stale nibble never looks valid
   always_ff @(posedge clk) begin
      idle_d <= idle_d + 4'h7;
   end

   // Cable mode feeds our own transmit straight back to the receiver
   always_comb begin
      src = cable ? line_tx : pat;
      line_rx = src.en ? src : '{en: 1'b0, d: idle_d};
   end
endmodule

// [verification/plb_top_tb.sv]
// Self-checking bench for loopback paths and register bit kinds
`timescale 1ns/100ps
module plb_top_tb;
   import plb_pkg::*;
   localparam int LD = 3;
   logic              clk = 1'b0;
   logic              rst = 1'b1;
   logic [PLB_AW-1:0] paddr = '0;
   logic              psel = 1'b0;
   logic              penable = 1'b0;
   logic              pwrite = 1'b0;
   logic [PLB_DW-1:0] pwdata = '0;
   logic [PLB_DW-1:0] prdata;
   logic              pready;
   logic              pslverr;
   plb_nib_s          mac_tx = '0;
   plb_nib_s          mac_rx;
   logic              mac_col;
   plb_nib_s          line_rx;
   logic              line_rx_err = 1'b0;
   logic              line_link_ok = 1'b1;
   logic              rmii_mode = 1'b1;
   plb_nib_s          line_tx;
   logic              line_tx_pwr_en;
   logic              cable = 1'b0;
   plb_nib_s          pat = '{en: 1'b1, d: 4'h5};
   int                failures = 0;
   int                n_tests = 0;
   logic [31:0]       rd;
   logic              er;

   always #20 clk = ~clk;

   plb_top #(.LOOP_DEPTH(LD)) DUT (
      .clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .mac_tx(mac_tx), .mac_rx(mac_rx), .mac_col(mac_col),
      .line_rx(line_rx), .line_rx_err(line_rx_err), .line_link_ok(line_link_ok),
      .rmii_mode(rmii_mode), .line_tx(line_tx), .line_tx_pwr_en(line_tx_pwr_en)
   );

   plb_line_model partner (
      .clk(clk), .cable(cable), .pat(pat), .line_tx(line_tx), .line_rx(line_rx)
   );

   task automatic wrap_up();
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen high at an edge
   task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                      output logic [31:0] d, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      paddr <= a;
      pwrite <= w;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         failures++;
         wrap_up();
      end
      d = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] wd);
      logic [31:0] d;
      logic        e;
      apb(a, 1'b1, wd, d, e);
   endtask

   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
      logic [31:0] d;
      logic        e;
      apb(a, 1'b0, 32'h0, d, e);
      check(d & m, exp);
   endtask

   // Steady-state path check, so no latency guess is needed
   task automatic settle(input logic [4:0] rx, input logic [4:0] tx, input logic pwr);
      repeat (8) @(posedge clk);
      #1;
      check({27'h0, mac_rx}, {27'h0, rx});
      check({27'h0, line_tx}, {27'h0, tx});
      check({31'h0, line_tx_pwr_en}, {31'h0, pwr});
      // Return on an edge so the caller's next drive lands on the clock
      @(posedge clk);
   endtask

   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      rdchk(PLB_CTRL_OFS, 32'h3100, '1);
      rdchk(PLB_MODE_OFS, 32'h0102, '1);
      apb(8'h20, 1'b0, 32'h0, rd, er);
      check({31'h0, er}, 32'h1);
      check(rd, 32'h0);
      // Normal paths in both directions
      mac_tx <= '{en: 1'b1, d: 4'hA};
      settle(5'h15, 5'h1A, 1'b1);
      rdchk(PLB_EVT_OFS, 32'h1, 32'h1);
      wr(PLB_EVT_OFS, 32'h0);
      rdchk(PLB_EVT_OFS, 32'h1, 32'h1);
      wr(PLB_EVT_OFS, 32'h1);
      rdchk(PLB_EVT_OFS, 32'h0, 32'h1);
      // Near-end loop with exact latency, transmitter off, no collision
      wr(PLB_CTRL_OFS, 32'h4100);
      repeat (4) @(posedge clk);
      for (int j = 0; j < 16; j++) begin
         @(posedge clk);
         mac_tx <= '{en: 1'b1, d: 4'(j)};
         #1;
         if (j > LD) check({27'h0, mac_rx}, 32'(16 + j - LD - 1));
         check({31'h0, line_tx_pwr_en}, 32'h0);
         check({31'h0, mac_col}, 32'h0);
      end
      rdchk(PLB_CTRL_OFS, 32'h4100, '1);
      // Collision test is the one way to raise COL inside the near loop
      wr(PLB_CTRL_OFS, 32'h4180);
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, mac_col}, 32'h1);
      // Echo request without the reduced interface is refused
      wr(PLB_CTRL_OFS, 32'h3100);
      mac_tx <= '{en: 1'b1, d: 4'hA};
      rmii_mode <= 1'b0;
      pat <= '{en: 1'b1, d: 4'h3};
      wr(PLB_MODE_OFS, 32'h0200);
      settle(5'h13, 5'h1A, 1'b1);
      rmii_mode <= 1'b1;
      settle(5'h00, 5'h13, 1'b1);
      check({31'h0, mac_col}, 32'h0);
      wr(PLB_MODE_OFS, 32'h0);
      rdchk(PLB_EVT_OFS, 32'h100, 32'h100);
      wr(PLB_EVT_OFS, 32'h0);
      rdchk(PLB_EVT_OFS, 32'h0, 32'h100);
      // Isolation and power down on the normal path, then half duplex collision
      wr(PLB_CTRL_OFS, 32'h3D00);
      settle(5'h00, 5'h1A, 1'b0);
      check({31'h0, mac_col}, 32'h0);
      wr(PLB_CTRL_OFS, 32'h3000);
      repeat (2) @(posedge clk);
      #1;
      check({31'h0, mac_col}, 32'h1);
      wr(PLB_CTRL_OFS, 32'h3100);
      // Short cable from transmitter back to receiver
      cable <= 1'b1;
      settle(5'h1A, 5'h1A, 1'b1);
      cable <= 1'b0;
      // Read-only, self-setting and plain fields
      wr(PLB_MODE_OFS, 32'h00A0);
      rdchk(PLB_MODE_OFS, 32'h01A2, '1);
      // Counter preset, read-clear and sticky error
      wr(PLB_PRE_OFS, 32'h0010);
      rdchk(PLB_PRE_OFS, 32'h0, '1);
      line_rx_err <= 1'b1;
      repeat (2) @(posedge clk);
      line_rx_err <= 1'b0;
      repeat (4) @(posedge clk);
      rdchk(PLB_ERRC_OFS, 32'h11, '1);
      rdchk(PLB_ERRC_OFS, 32'h0, '1);
      wr(PLB_ERRC_OFS, 32'h5);
      rdchk(PLB_ERRC_OFS, 32'h0, '1);
      rdchk(PLB_STAT_OFS, 32'h10, 32'h10);
      rdchk(PLB_STAT_OFS, 32'h0, 32'h10);
      wr(PLB_STAT_OFS, 32'h10);
      rdchk(PLB_STAT_OFS, 32'h0, 32'h10);
      line_rx_err <= 1'b1;
      repeat (4) @(posedge clk);
      rdchk(PLB_STAT_OFS, 32'h10, 32'h10);
      rdchk(PLB_STAT_OFS, 32'h10, 32'h10);
      line_rx_err <= 1'b0;
      // Link drop latched low until read
      rdchk(PLB_STAT_OFS, 32'h4, 32'h4);
      line_link_ok <= 1'b0;
      repeat (4) @(posedge clk);
      line_link_ok <= 1'b1;
      repeat (4) @(posedge clk);
      rdchk(PLB_STAT_OFS, 32'h0, 32'h4);
      rdchk(PLB_STAT_OFS, 32'h4, 32'h4);
      // Self-clearing bits and soft reset with immune field
      wr(PLB_CTRL_OFS, 32'h3380);
      rdchk(PLB_CTRL_OFS, 32'h3180, '1);
      wr(PLB_CTRL_OFS, 32'h8000);
      rdchk(PLB_CTRL_OFS, 32'h3100, '1);
      rdchk(PLB_MODE_OFS, 32'h00A0, 32'h02F0);
      wrap_up();
   end
endmodule
